// *** hw/phy_reset_strap_powerdown.sv ***
// Reset sequencer, strap latch and dual-role power-down/interrupt pin with an Avalon-MM register slave.
// Assumes pins arrive asynchronously; external wiring resolves open-drain and strap pins from the enables.
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module phy_reset_strap_powerdown
   import phy_rst_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   // Avalon-MM slave
   input  wire logic [phy_rst_pkg::ADDR_W-1:0] address,
   input  wire logic                       read,
   input  wire logic                       write,
   input  wire logic [3:0]                 byteenable,
   input  wire logic [31:0]                writedata,
   output logic      [31:0]                readdata,
   output logic                            waitrequest,
   output logic                            irq,
   // Hardware reset pin
   input  wire logic                       hw_reset_low,
   // Dual-role power-down / interrupt pin
   input  wire logic                       powerdown_or_irq_pin_in,
   output logic                            powerdown_or_irq_pin_out,
   output logic                            powerdown_or_irq_pin_oe,
   // Strap pins {autoneg, mode1, mode0, address[4:0]}
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] strap_pin_in,
   output logic      [phy_rst_pkg::STRAP_W-1:0] strap_pin_out,
   output logic      [phy_rst_pkg::STRAP_W-1:0] strap_pin_oe,
   // Core side
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] func_out,
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] func_oe,
   input  wire logic                       core_irq_event,
   output phy_rst_pkg::strap_cfg_t         strap_cfg,
   output logic                            forced_link,
   output logic                            device_in_reset,
   output logic                            powerdown
);
   import phy_rst_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [STRAP_W+1:0] pins_s;
   logic               rst_low_s;
   logic               pd_pin_s;
   logic [STRAP_W-1:0] strap_s;

   pin_sync #(.WIDTH(STRAP_W + 2)) u_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in ({hw_reset_low, powerdown_or_irq_pin_in, strap_pin_in}),
      .sync_out (pins_s)
   );

   assign rst_low_s = ~pins_s[STRAP_W+1];
   assign pd_pin_s  = pins_s[STRAP_W];
   assign strap_s   = pins_s[STRAP_W-1:0];

   // ****************************************
   // Reset sequencer and strap latch
   // ****************************************
   rst_state_t           state;
   rst_state_t           next_state;
   logic [RST_CNT_W-1:0] low_cnt;
   logic [RST_CNT_W-1:0] next_low_cnt;
   strap_cfg_t           strap_sample;
   strap_cfg_t           next_strap_sample;
   strap_cfg_t           next_strap_cfg;
   logic                 release_evt;

   localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(RST_MIN_CYC - 1);

   always_comb
   begin
      next_state        = state;
      next_low_cnt      = '0;
      next_strap_sample = strap_sample;
      next_strap_cfg    = strap_cfg;
      release_evt       = 1'b0;
      if (rst_low_s && low_cnt != RST_LAST)
         next_low_cnt = low_cnt + RST_CNT_W'(1);
      else if (rst_low_s)
         next_low_cnt = low_cnt;
      unique case (state)
         ST_RUN:
         begin
            // Glitches shorter than the minimum are ignored
            if (rst_low_s && low_cnt == RST_LAST)
               next_state = ST_RESET;
         end
         ST_RESET:
         begin
            next_strap_sample = strap_cfg_t'(strap_s);
            if (!rst_low_s)
            begin
               next_state     = ST_RUN;
               // Live sample: the registered one may still hold the synchroniser's reset value at power-up
               next_strap_cfg = strap_cfg_t'(strap_s);
               release_evt    = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         // Power-up behaves as a hardware reset still in progress
         state        <= ST_RESET;
         low_cnt      <= '0;
         strap_sample <= STRAP_DEFAULT;
         strap_cfg    <= STRAP_DEFAULT;
      end
      else
      begin
         state        <= next_state;
         low_cnt      <= next_low_cnt;
         strap_sample <= next_strap_sample;
         strap_cfg    <= next_strap_cfg;
      end
   end

   // ****************************************
   // Registers and Avalon-MM slave
   // ****************************************
   pin_role_t         role;
   pin_role_t         next_role;
   logic [NUM_EV-1:0] status;
   logic [NUM_EV-1:0] next_status;
   logic [NUM_EV-1:0] mask;
   logic [NUM_EV-1:0] next_mask;
   logic [NUM_EV-1:0] ev;
   logic [31:0]       next_readdata;
   logic              next_waitrequest;
   logic              next_irq;
   logic              next_powerdown;
   logic              access;
   logic              in_reset;

   assign in_reset = (state == ST_RESET);
   assign access   = (read || write) && !waitrequest;

   always_comb
   begin
      next_waitrequest = !((read || write) && waitrequest);
      next_readdata    = readdata;
      next_role        = role;
      next_mask        = mask;
      next_powerdown   = !in_reset && role == ROLE_POWERDOWN && !pd_pin_s;
      ev               = '0;
      ev[EV_RESET_DONE] = release_evt;
      ev[EV_POWERDOWN]  = next_powerdown && !powerdown;
      ev[EV_CORE]       = core_irq_event && !in_reset;
      next_status      = status;
      // Read data is prepared on the first cycle so it stands with waitrequest low
      if (read && waitrequest)
      begin
         unique case (address)
            OFS_CTRL:   next_readdata = 32'(role);
            OFS_STRAP:  next_readdata = 32'(strap_cfg);
            OFS_STATUS: next_readdata = 32'(status);
            OFS_MASK:   next_readdata = 32'(mask);
            default:    next_readdata = 32'h0000_0000;
         endcase
      end
      // Clear only what the read reported, so an event landing during the access survives
      if (access && read && address == OFS_STATUS)
         next_status = status & ~readdata[NUM_EV-1:0];
      if (access && write && byteenable[0])
      begin
         if (address == OFS_CTRL)
            next_role = pin_role_t'(writedata[CTRL_ROLE_BIT]);
         if (address == OFS_MASK)
            next_mask = writedata[NUM_EV-1:0];
      end
      // A new event wins over the read clear
      next_status = next_status | ev;
      if (in_reset)
      begin
         // Software state is held at its initial value through a reset
         next_role = pin_role_t'(CTRL_ROLE_RESET);
         next_mask = EV_RESET;
         // Only the release event may survive a reset
         next_status = ev;
      end
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         role        <= pin_role_t'(CTRL_ROLE_RESET);
         mask        <= EV_RESET;
         status      <= EV_RESET;
         readdata    <= 32'h0000_0000;
         waitrequest <= 1'b1;
         irq         <= 1'b0;
         powerdown   <= 1'b0;
      end
      else
      begin
         role        <= next_role;
         mask        <= next_mask;
         status      <= next_status;
         readdata    <= next_readdata;
         waitrequest <= next_waitrequest;
         irq         <= next_irq;
         powerdown   <= next_powerdown;
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   logic               next_pd_oe;
   logic [STRAP_W-1:0] next_strap_out;
   logic [STRAP_W-1:0] next_strap_oe;
   logic               next_forced;

   // Open drain: only ever low, released otherwise
   assign powerdown_or_irq_pin_out = 1'b0;

   always_comb
   begin
      next_pd_oe     = role == ROLE_IRQ && next_irq && !in_reset;
      // Straps stay released while reset is active so their levels can be sampled
      next_strap_out = in_reset ? '0 : func_out;
      next_strap_oe  = in_reset ? '0 : func_oe;
      next_forced    = !next_strap_cfg.autoneg;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         powerdown_or_irq_pin_oe <= 1'b0;
         strap_pin_out           <= '0;
         strap_pin_oe            <= '0;
         forced_link             <= 1'b0;
         device_in_reset         <= 1'b1;
      end
      else
      begin
         powerdown_or_irq_pin_oe <= next_pd_oe;
         strap_pin_out           <= next_strap_out;
         strap_pin_oe            <= next_strap_oe;
         forced_link             <= next_forced;
         device_in_reset         <= (next_state == ST_RESET);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   localparam int RST_LAST_I = RST_MIN_CYC - 1;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_rst_min;
      $rose(in_reset) |-> $past(low_cnt) == RST_LAST_I && $past(rst_low_s);
   endproperty
   a_rst_min: assert property (p_rst_min) else $error("reset entered before minimum low time");

   property p_regs_init;
      in_reset |=> role == ROLE_POWERDOWN && mask == EV_RESET && status[NUM_EV-1:1] == '0;
   endproperty
   a_regs_init: assert property (p_regs_init) else $error("registers not initial during reset");

   property p_strap_reload;
      $fell(in_reset) |-> strap_cfg == strap_cfg_t'($past(strap_s));
   endproperty
   a_strap_reload: assert property (p_strap_reload) else $error("straps not reloaded at release");

   property p_role_default;
      $fell(in_reset) |-> role == ROLE_POWERDOWN;
   endproperty
   a_role_default: assert property (p_role_default) else $error("pin role not power-down after reset");

   property p_role_write;
      access && write && byteenable[0] && address == OFS_CTRL && !in_reset
         |=> role == pin_role_t'($past(writedata[CTRL_ROLE_BIT]));
   endproperty
   a_role_write: assert property (p_role_write) else $error("control write did not set pin role");

   property p_pd_enter;
      !in_reset && role == ROLE_POWERDOWN && !pd_pin_s |=> powerdown;
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered on low pin");

   property p_irq_drive;
      $past(role == ROLE_IRQ && !in_reset) && irq |-> powerdown_or_irq_pin_oe;
   endproperty
   a_irq_drive: assert property (p_irq_drive) else $error("interrupt pin not pulled low");

   property p_od_only;
      powerdown_or_irq_pin_oe |-> powerdown_or_irq_pin_out == 1'b0 && $past(role) == ROLE_IRQ;
   endproperty
   a_od_only: assert property (p_od_only) else $error("dual-role pin driven outside interrupt role");

   property p_sample;
      in_reset ##1 in_reset |-> strap_sample == strap_cfg_t'($past(strap_s));
   endproperty
   a_sample: assert property (p_sample) else $error("strap pins not sampled in reset");

   property p_release_pins;
      in_reset ##1 1'b1 |-> strap_pin_oe == '0;
   endproperty
   a_release_pins: assert property (p_release_pins) else $error("strap pin driven during reset");

   property p_func_pins;
      !in_reset |=> strap_pin_oe == $past(func_oe);
   endproperty
   a_func_pins: assert property (p_func_pins) else $error("strap pin not functional after reset");

   property p_defaults;
      @(posedge clk_sys) $past(sys_rst) |-> strap_cfg == STRAP_DEFAULT;
   endproperty
   a_defaults: assert property (p_defaults) else $error("strap defaults wrong after power-up");

   property p_forced;
      ##1 forced_link == !strap_cfg.autoneg;
   endproperty
   a_forced: assert property (p_forced) else $error("forced link decode wrong");

   property p_hold;
      !in_reset && $past(!in_reset) |-> $stable(strap_cfg);
   endproperty
   a_hold: assert property (p_hold) else $error("latched straps changed outside reset");

   c_hw_reset:   cover property ($fell(in_reset));
   c_pd_mode:    cover property ($rose(powerdown));
   c_irq_pin:    cover property ($rose(powerdown_or_irq_pin_oe));
   c_status_rd:  cover property (access && read && address == OFS_STATUS && status != '0);

endmodule

// *** hw/phy_rst_pkg.sv ***
// Constants, field layouts and carrier types of the reset, strap and power-down block.
// Assumes a single 100 MHz system clock and a synchronous active-high system reset.
package phy_rst_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ     = 100;
   localparam int RST_MIN_NS  = 1000;
   // Least time, so round up
   localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_CNT_W   = 8;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int          ADDR_W     = 4;
   localparam logic [3:0]  OFS_CTRL   = 4'h0;
   localparam logic [3:0]  OFS_STRAP  = 4'h4;
   localparam logic [3:0]  OFS_STATUS = 4'h8;
   localparam logic [3:0]  OFS_MASK   = 4'hC;

   localparam int          CTRL_ROLE_BIT   = 0;
   localparam logic        CTRL_ROLE_RESET = 1'h0;

   localparam int          NUM_EV          = 3;
   localparam int          EV_RESET_DONE   = 0;
   localparam int          EV_POWERDOWN    = 1;
   localparam int          EV_CORE         = 2;
   localparam logic [2:0]  EV_RESET        = 3'h0;

   // ****************************************
   // Carriers
   // ****************************************
   // Layout equals the strap pin vector: bit 0 is management address pin 0
   typedef struct packed {
      logic       autoneg;
      logic [1:0] link_mode;
      logic [4:0] mgmt_address;
   } strap_cfg_t;

   localparam int         STRAP_W       = 8;
   localparam strap_cfg_t STRAP_DEFAULT = '{autoneg: 1'h1, link_mode: 2'h3, mgmt_address: 5'h00};

   typedef enum logic {ST_RUN, ST_RESET} rst_state_t;

   typedef enum logic {ROLE_POWERDOWN, ROLE_IRQ} pin_role_t;

endpackage

// *** hw/pin_sync.sv ***
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // Stage one feeds stage two only
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// *** test/board_model.sv ***
// Board side of the block: reset source, strap resistors and the open-drain pull-up.
// Assumes the bench chooses resistor fitting, reset hold time and any external pull-down.
`timescale 1ns/1ps
module board_model
   import phy_rst_pkg::*;
(
   // Bench controls
   input  wire logic                            hold_reset,
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] res_en,
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] res_val,
   input  wire logic                            pd_pull_low,
   // Device pins
   output logic                                 hw_reset_low,
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] strap_out,
   input  wire logic [phy_rst_pkg::STRAP_W-1:0] strap_oe,
   output logic      [phy_rst_pkg::STRAP_W-1:0] strap_in,
   input  wire logic                            pd_out,
   input  wire logic                            pd_oe,
   output logic                                 pd_in
);
   // ****************************************
   // Pin resolution
   // ****************************************
   // hw_reset keeps hold_reset up past the minimum low time; t_short releases it after 50 cycles
   assign hw_reset_low = !hold_reset;

   always_comb
   begin
      for (int i = 0; i < STRAP_W; i++)
      begin
         if (strap_oe[i])
            strap_in[i] = strap_out[i];
         else if (res_en[i])
            strap_in[i] = res_val[i];
         else
            strap_in[i] = STRAP_DEFAULT[i];
      end
   end

   // Open drain: a driven high is not seen, the pull-up gives the high level
   assign pd_in = ((pd_oe && !pd_out) || pd_pull_low) ? 1'h0 : 1'h1;
endmodule

// *** test/tb_phy_reset_strap_powerdown.sv ***
// Self-checking bench of the reset, strap latch and dual-role pin block.
// Assumes board_model for the pins and a register slave answering through waitrequest.
`timescale 1ns/1ps
module tb_phy_reset_strap_powerdown;
   import phy_rst_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic               clk_sys        = 1'h0;
   logic               sys_rst        = 1'h1;
   logic [ADDR_W-1:0]  address        = '0;
   logic               read           = 1'h0;
   logic               write          = 1'h0;
   logic [31:0]        writedata      = '0;
   logic [STRAP_W-1:0] func_out       = 8'h3C;
   logic [STRAP_W-1:0] func_oe        = 8'hA5;
   logic               core_irq_event = 1'h0;
   logic               hold_reset     = 1'h0;
   logic               pd_pull_low    = 1'h0;
   logic [STRAP_W-1:0] res_en         = '0;
   logic [STRAP_W-1:0] res_val        = '0;
   logic [31:0]        readdata;
   logic               waitrequest, irq, pd_in, pd_out, pd_oe, hw_reset_low;
   logic               forced_link, device_in_reset, powerdown;
   logic [STRAP_W-1:0] strap_in, strap_out, strap_oe;
   strap_cfg_t         strap_cfg;
   int                 n_mismatch     = 0;
   int                 num_checks     = 0;

   always #5 clk_sys = ~clk_sys;

   phy_reset_strap_powerdown dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .hw_reset_low(hw_reset_low), .powerdown_or_irq_pin_in(pd_in),
      .powerdown_or_irq_pin_out(pd_out), .powerdown_or_irq_pin_oe(pd_oe), .strap_pin_in(strap_in),
      .strap_pin_out(strap_out), .strap_pin_oe(strap_oe), .func_out(func_out), .func_oe(func_oe),
      .core_irq_event(core_irq_event), .strap_cfg(strap_cfg), .forced_link(forced_link),
      .device_in_reset(device_in_reset), .powerdown(powerdown));

   board_model board (.hold_reset(hold_reset), .res_en(res_en), .res_val(res_val),
      .pd_pull_low(pd_pull_low), .hw_reset_low(hw_reset_low), .strap_out(strap_out),
      .strap_oe(strap_oe), .strap_in(strap_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_in(pd_in));

   // ****************************************
   // Shared tasks
   // ****************************************
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task timeout(input string what);
      n_mismatch++;
      $display("wrong value at %0t: %s timed out", $time, what);
      summarize();
   endtask

   // Request held until waitrequest is sampled low, released only after that edge
   task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      address   <= a;
      writedata <= d;
      write     <= wr_en;
      read      <= !wr_en;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (waitrequest !== 1'h0 && n < 20);
      if (waitrequest !== 1'h0)
         timeout("bus access");
      q = readdata;
      write <= 1'h0;
      read  <= 1'h0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk(q, exp, what);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask

   task automatic wait_for(ref logic s, input logic v, input int max, input string what);
      int n;
      n = 0;
      while (s !== v && n < max)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (s !== v)
         timeout(what);
   endtask

   task hw_reset;
      @(posedge clk_sys);
      hold_reset <= 1'h1;
      repeat (110) @(posedge clk_sys);
      chk(device_in_reset, 1'h1, "reset entered");
      chk(strap_oe, 8'h00, "straps released in reset");
      hold_reset <= 1'h0;
      wait_for(device_in_reset, 1'h0, 20, "reset release");
   endtask

   task pulse_event;
      @(posedge clk_sys);
      core_irq_event <= 1'h1;
      @(posedge clk_sys);
      core_irq_event <= 1'h0;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_defaults;
      wait_for(device_in_reset, 1'h0, 20, "first release");
      @(posedge clk_sys);
      chk(strap_cfg, STRAP_DEFAULT, "default straps");
      chk(forced_link, 1'h0, "default negotiation");
      chk(pd_oe, 1'h0, "pin not driven");
      rd_chk(OFS_STRAP, {24'h0, STRAP_DEFAULT}, "strap register");
      rd_chk(OFS_STATUS, 32'h1, "reset done");
      rd_chk(OFS_CTRL, 32'h0, "role after reset");
      rd_chk(4'h2, 32'h0, "unmapped read");
   endtask

   task t_straps;
      logic [7:0] tbl [3];
      tbl = '{8'h55, 8'h1F, 8'h81};
      res_en <= 8'hFF;
      foreach (tbl[i])
      begin
         res_val <= tbl[i];
         hw_reset();
         chk(strap_cfg, tbl[i], "latched straps");
         repeat (2) @(posedge clk_sys);
         chk(forced_link, !tbl[i][7], "forced link");
         chk({strap_oe, strap_out}, {func_oe, func_out}, "functional drive");
         res_val <= ~tbl[i];
         repeat (5) @(posedge clk_sys);
         chk(strap_cfg, tbl[i], "straps held");
      end
      res_en <= 8'h00;
   endtask

   // A low shorter than the minimum must not start a reset
   task t_short;
      logic seen;
      seen = 1'h0;
      @(posedge clk_sys);
      hold_reset <= 1'h1;
      repeat (50) @(posedge clk_sys);
      hold_reset <= 1'h0;
      repeat (120)
      begin
         @(posedge clk_sys);
         seen = seen | (device_in_reset !== 1'h0);
      end
      chk(seen, 1'h0, "short low ignored");
   endtask

   task t_irq;
      wr(OFS_MASK, 32'h4);
      pulse_event();
      wait_for(irq, 1'h1, 5, "irq in input role");
      chk(pd_oe, 1'h0, "no drive in input role");
      rd_chk(OFS_STATUS, 32'h5, "status");
      wr(OFS_CTRL, 32'h1);
      rd_chk(OFS_CTRL, 32'h1, "role written");
      pulse_event();
      wait_for(irq, 1'h1, 5, "irq in output role");
      @(posedge clk_sys);
      chk({pd_oe, pd_out, pd_in}, 3'h4, "pin pulled low");
      rd_chk(OFS_STATUS, 32'h4, "core event");
      chk(powerdown, 1'h0, "own pull not a power-down");
      wait_for(irq, 1'h0, 5, "irq clear");
      @(posedge clk_sys);
      chk({pd_oe, pd_in}, 2'h1, "pin released");
      pulse_event();
      hw_reset();
      rd_chk(OFS_CTRL, 32'h0, "role reset");
      rd_chk(OFS_MASK, 32'h0, "mask reset");
      rd_chk(OFS_STATUS, 32'h1, "status cleared by reset");
   endtask

   task t_powerdown;
      @(posedge clk_sys);
      pd_pull_low <= 1'h1;
      wait_for(powerdown, 1'h1, 10, "power-down entry");
      rd_chk(OFS_STATUS, 32'h2, "power-down event");
      chk(irq, 1'h0, "masked events");
      pd_pull_low <= 1'h0;
   endtask

   initial
   begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'h0;
      t_defaults();
      t_straps();
      t_short();
      t_irq();
      t_powerdown();
      summarize();
   end
endmodule
